// ---- bench/pcc_core_chk.sv ----
// checker for vector fetch, fetch port and pin outputs
`timescale 1ns/1ps
module pcc_core_chk
(
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // pins
  input wire        test_boot_i,
  input wire        clkmon_reset_i,
  input wire        watchdog_reset_cause_i,
  input wire        irq_req_i,
  input wire        irq_take_o,
  input wire        stop_enter_o,
  // fetch port
  input wire [15:0] mem_adr_o,
  input wire        mem_req_o,
  input wire        mem_ack_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  vec_por_a: assert property ($fell(rst_i) && !test_boot_i |=> mem_adr_o == 16'hFFFE)
    else $error("power-on vector wrong");
  vec_test_a: assert property ($fell(rst_i) && test_boot_i |=> mem_adr_o == 16'hBFFE)
    else $error("test vector wrong");
  vec_clkmon_a: assert property ($rose(clkmon_reset_i) && !test_boot_i |->
    ##[1:4] mem_req_o && mem_adr_o == 16'hFFFC) else $error("clock monitor vector wrong");
  vec_wdog_a: assert property ($rose(watchdog_reset_cause_i) |->
    ##[1:4] mem_adr_o == (test_boot_i ? 16'hBFFE : 16'hFFFA)) else $error("watchdog vector");
  fetch_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_adr_o))
    else $error("fetch request dropped");
  byte_step_a: assert property (mem_req_o && mem_ack_i ##1 mem_req_o |->
    mem_adr_o == $past(mem_adr_o) + 16'h0001) else $error("fetch address step");
  irq_quiet_a: assert property (!irq_req_i [*5] |-> !irq_take_o)
    else $error("take without request");
  stop_pulse_a: assert property (stop_enter_o |=> !stop_enter_o)
    else $error("stop pulse too long");
endmodule
bind pcc_core pcc_core_chk chk (.clk_i(clk_i), .rst_i(rst_i), .test_boot_i(test_boot_i),
  .clkmon_reset_i(clkmon_reset_i), .watchdog_reset_cause_i(watchdog_reset_cause_i),
  .irq_req_i(irq_req_i), .irq_take_o(irq_take_o), .stop_enter_o(stop_enter_o),
  .mem_adr_o(mem_adr_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i));

// ---- bench/pcc_mem_model.sv ----
// byte memory answering the fetch port, fast or slow
`timescale 1ns/1ps
module pcc_mem_model
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire [15:0] adr_i,
  input  wire        req_i,
  output reg  [7:0]  dat_o,
  output reg         ack_o
);
  reg [1:0] wait_reg;
  function [7:0] byte_at(input [15:0] a);
    case (a)
      16'hFFFE: byte_at = 8'h12; // high byte at lower address
      16'hFFFF: byte_at = 8'h34;
      16'hFFFC: byte_at = 8'h23;
      16'hFFFD: byte_at = 8'h45;
      16'hFFFA: byte_at = 8'h34;
      16'hFFFB: byte_at = 8'h56;
      16'hBFFE: byte_at = 8'h45;
      16'hBFFF: byte_at = 8'h67;
      16'h1234: byte_at = 8'h18;
      16'h1235: byte_at = 8'hA6;
      16'h1236: byte_at = 8'h80;
      16'h1237: byte_at = 8'hB6;
      16'h1238: byte_at = 8'h12;
      16'h1239: byte_at = 8'h34;
      default: byte_at = a[15:8] ^ a[7:0];
    endcase
  endfunction
  // data toggles when not answering; reset loads 8'hA5
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    wait_reg <= 2'h0;
    dat_o <= rst_i ? 8'hA5 : ~dat_o;
    if (!rst_i && req_i && !ack_o && wait_reg < {slow_i, 1'b0})
      wait_reg <= wait_reg + 2'h1;
    else if (!rst_i && req_i && !ack_o)
    begin
      ack_o <= 1'b1;
      dat_o <= byte_at(adr_i);
    end
  end
endmodule

// ---- bench/testbench.sv ----
// testbench for the program counter, flag and addressing core
`timescale 1ns/1ps
`include "pcc_defs.vh"
module testbench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] dat = 32'h0;
  reg         we = 1'b0;
  reg         cyc = 1'b0;
  reg         tb = 1'b0;
  reg         cm = 1'b0;
  reg         wd = 1'b0;
  reg         irq = 1'b0;
  reg         slow = 1'b0;
  reg         xm = 1'b0;
  reg         stop_seen = 1'b0;
  reg  [31:0] rd;
  reg  [31:0] v;
  wire [31:0] dout;
  wire        ack;
  wire        itake;
  wire        xtake;
  wire        senter;
  wire [15:0] madr;
  wire        mreq;
  wire [7:0]  mdat;
  wire        mack;
  integer     fails = 0;
  integer     total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  // latches the one-cycle stop pulse
  always @(posedge clk_i)
    if (senter)
      stop_seen <= 1'b1;
  pcc_core dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .sel_i(4'hF),
    .we_i(we), .cyc_i(cyc), .stb_i(cyc), .dat_o(dout), .ack_o(ack), .clkmon_reset_i(cm),
    .watchdog_reset_cause_i(wd), .test_boot_i(tb), .irq_req_i(irq), .nonmaskable_req_i(xm),
    .irq_take_o(itake), .nonmaskable_req_take_o(xtake), .stop_enter_o(senter), .mem_adr_o(madr),
    .mem_req_o(mreq),
    .mem_dat_i(mdat), .mem_ack_i(mack));
  pcc_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .adr_i(madr), .req_i(mreq),
    .dat_o(mdat), .ack_o(mack));
  task end_of_test;
  begin
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 9)
    begin
      n = n + 1;
      @(posedge clk_i);
    end
    rd = dout;
    cyc <= 1'b0;
    if (n == 9)
    begin
      fails = fails + 1;
      $display("ERROR %0t: no bus answer", $time);
      end_of_test;
    end
  end
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
  begin
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  end
  endtask
  task idle;
    integer n;
  begin
    n = 0;
    rd = 0;
    while (rd[2:0] !== 3'h2 && n < 40)
    begin
      wb(1'b0, `PCC_R_STAT, 32'h0);
      n = n + 1;
    end
    chk(rd & 32'h7, 32'h2);
  end
  endtask
  task alu(input [4:0] op, input [7:0] a, input [7:0] b);
  begin
    wb(1'b1, `PCC_R_ALUA, {24'h0, a});
    wb(1'b1, `PCC_R_ALUB, {24'h0, b});
    wb(1'b1, `PCC_R_ALUCMD, {27'h0, op});
  end
  endtask
  task do_reset(input t);
  begin
    tb <= t;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    idle;
  end
  endtask
  task restart(input c);
  begin
    cm <= c;
    wd <= !c;
    repeat (4) @(posedge clk_i);
    cm <= 1'b0;
    wd <= 1'b0;
    idle;
  end
  endtask
  initial
  begin
    do_reset(1'b0);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h1234);
    rdc(`PCC_R_CCR, 32'hFF, 32'hD0);
    irq <= 1'b1;
    xm <= 1'b1;
    alu(`PCC_OP_ADD, 8'h08, 8'h08);
    rdc(`PCC_R_CCR, 32'h2F, 32'h20);
    alu(`PCC_OP_ADD, 8'h7F, 8'h01);
    rdc(`PCC_R_CCR, 32'h2F, 32'h2A);
    alu(`PCC_OP_ADD, 8'h80, 8'h80);
    rdc(`PCC_R_CCR, 32'h0F, 32'h07);
    alu(`PCC_OP_CMP, 8'h05, 8'h06);
    rdc(`PCC_R_CCR, 32'h0F, 32'h09);
    rdc(`PCC_R_RESULT, 32'hFF, 32'h00);
    alu(`PCC_OP_AND, 8'hF0, 8'h0F);
    rdc(`PCC_R_CCR, 32'h0E, 32'h04);
    alu(`PCC_OP_LOAD, 8'h00, 8'h80);
    rdc(`PCC_R_CCR, 32'h0E, 32'h08);
    alu(`PCC_OP_ASL, 8'h81, 8'h00);
    rdc(`PCC_R_RESULT, 32'hFF, 32'h02);
    alu(`PCC_OP_ROR, 8'h00, 8'h00);
    rdc(`PCC_R_RESULT, 32'hFF, 32'h80);
    wb(1'b1, `PCC_R_IDX1, 32'hFFFF);
    rdc(`PCC_R_CCR, 32'hFF, 32'hDA);
    v = 32'hDE;
    alu(`PCC_OP_INC1, 8'h00, 8'h00);
    rdc(`PCC_R_CCR, 32'hFF, v);
    alu(`PCC_OP_ABX1, 8'h00, 8'h05);
    alu(`PCC_OP_NOFLAG, 8'h00, 8'h00);
    rdc(`PCC_R_CCR, 32'hFF, v);
    rdc(`PCC_R_IDX1, 32'hFFFF, 32'h0005);
    alu(`PCC_OP_TAP, 8'h80, 8'h00);
    rdc(`PCC_R_CCR, 32'hFF, 32'h80);
    chk({31'h0, itake}, 32'h1);
    chk({31'h0, xtake}, 32'h1);
    wb(1'b1, `PCC_R_CTRL, 32'h2);
    rdc(`PCC_R_STAT, 32'h40, 32'h40);
    chk({31'h0, stop_seen}, 32'h0);
    alu(`PCC_OP_RTI, 8'h40, 8'h00);
    rdc(`PCC_R_CCR, 32'h40, 32'h00);
    alu(`PCC_OP_INTACK, 8'h01, 8'h00);
    rdc(`PCC_R_CCR, 32'h50, 32'h50);
    chk({31'h0, itake}, 32'h0);
    chk({31'h0, xtake}, 32'h0);
    alu(`PCC_OP_TAP, 8'h00, 8'h00);
    wb(1'b1, `PCC_R_CTRL, 32'h2);
    rdc(`PCC_R_STAT, 32'h40, 32'h00);
    chk({31'h0, stop_seen}, 32'h1);
    wb(1'b1, `PCC_R_IDX2, 32'hFFF0);
    slow <= 1'b1;
    wb(1'b1, `PCC_R_CTRL, 32'h1);
    idle;
    rdc(`PCC_R_EA, 32'hFFFF, 32'h0070);
    rdc(`PCC_R_STAT, 32'h7F80, 32'h3880);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h1237);
    wb(1'b1, `PCC_R_CTRL, 32'h1);
    idle;
    rdc(`PCC_R_EA, 32'hFFFF, 32'h1234);
    rdc(`PCC_R_INSTR, 32'hFFFFFFFF, 32'h001234B6);
    rdc(`PCC_R_STAT, 32'h7F80, 32'h3600);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h123A);
    restart(1'b1);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h2345);
    rdc(`PCC_R_CCR, 32'hFF, 32'hD0);
    restart(1'b0);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h3456);
    do_reset(1'b1);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h4567);
    restart(1'b0);
    rdc(`PCC_R_IP, 32'hFFFF, 32'h4567);
    end_of_test;
  end
endmodule

// ---- logic/pcc_core.v ----
// program counter, flag register and addressing core with wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_core
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // reset causes and mode pins
  input  wire        clkmon_reset_i,
  input  wire        watchdog_reset_cause_i,
  input  wire        test_boot_i,
  // interrupt request pins
  input  wire        irq_req_i,
  input  wire        nonmaskable_req_i,
  output reg         irq_take_o,
  output reg         nonmaskable_req_take_o,
  output reg         stop_enter_o,
  // byte fetch port
  output reg  [15:0] mem_adr_o,
  output reg         mem_req_o,
  input  wire [7:0]  mem_dat_i,
  input  wire        mem_ack_i
);
  localparam ST_VHI  = 3'h0;
  localparam ST_VLO  = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_OP   = 3'h3;
  localparam ST_OPND = 3'h4;

  // pin synchronisers
  reg  [1:0]  cm_sync_reg;
  reg  [1:0]  wd_sync_reg;
  reg  [1:0]  tb_sync_reg;
  reg  [1:0]  irq_sync_reg;
  reg  [1:0]  nonmaskable_req_sync_reg;
  reg         cm_old_reg;
  reg         wd_old_reg;
  // core state
  reg  [2:0]  state_reg;
  reg  [15:0] instr_pointer;
  reg  [7:0]  cond_flags_reg;
  reg  [15:0] index_reg_first;
  reg  [15:0] index_reg_second;
  reg  [15:0] vec_reg;
  reg  [1:0]  page_reg;
  reg  [7:0]  opcode_reg;
  reg  [2:0]  mode_reg;
  reg  [1:0]  need_reg;
  reg  [1:0]  got_reg;
  reg  [7:0]  b1_reg;
  reg  [23:0] opnd_reg;
  reg  [15:0] ea_reg;
  reg  [2:0]  len_reg;
  reg  [15:0] alu_a_reg;
  reg  [15:0] alu_b_reg;
  reg  [15:0] result_reg;
  reg         stop_nop_reg;

  wire        wb_req    = cyc_i & stb_i & ~ack_o;
  wire        wb_wr     = wb_req & we_i & sel_i[0];
  wire        cm_rise   = cm_sync_reg[1] & ~cm_old_reg;
  wire        wd_rise   = wd_sync_reg[1] & ~wd_old_reg;
  wire        step_cmd  = wb_wr & (adr_i == `PCC_R_CTRL) & dat_i[`PCC_CTRL_STEP];
  wire        stop_cmd  = wb_wr & (adr_i == `PCC_R_CTRL) & dat_i[`PCC_CTRL_STOP];
  wire        alu_cmd   = wb_wr & (adr_i == `PCC_R_ALUCMD);
  wire [4:0]  alu_op    = dat_i[4:0];
  wire [7:0]  a8        = alu_a_reg[7:0];
  wire [7:0]  b8        = alu_b_reg[7:0];
  wire        cin       = (alu_op == `PCC_OP_ADC) & cond_flags_reg[`PCC_F_C];
  wire [8:0]  sum9      = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
  wire [4:0]  hsum      = {1'b0, a8[3:0]} + {1'b0, b8[3:0]} + {4'h0, cin};
  wire [8:0]  dif9      = {1'b0, a8} - {1'b0, b8};
  wire        is_pre    = (mem_dat_i == `PCC_PRE_P1) | (mem_dat_i == `PCC_PRE_P2) |
                          (mem_dat_i == `PCC_PRE_P3);

  // opcode class: mode and operand count
  reg  [2:0]  dec_mode;
  reg  [1:0]  dec_need;
  always @*
  begin
    dec_mode = `PCC_M_INH;
    dec_need = 2'd0;
    case (mem_dat_i[7:4])
      4'h8, 4'hC:
      begin
        dec_mode = `PCC_M_IMM;
        // 16-bit targets take two bytes
        dec_need = (mem_dat_i[3:0] == 4'h3 || mem_dat_i[3:0] == 4'hC ||
                    mem_dat_i[3:0] == 4'hE) ? 2'd2 : 2'd1;
      end
      4'h9, 4'hD:
      begin
        dec_mode = `PCC_M_DIR;
        dec_need = 2'd1;
      end
      4'hA, 4'hE, 4'h6:
      begin
        dec_mode = `PCC_M_IDX;
        dec_need = 2'd1;
      end
      4'hB, 4'hF, 4'h7:
      begin
        dec_mode = `PCC_M_EXT;
        dec_need = 2'd2;
      end
      4'h1:
      begin
        // bit manipulation carries mask and branch bytes
        case (mem_dat_i[3:0])
          4'h2, 4'h3:
          begin
            dec_mode = `PCC_M_DIR;
            dec_need = 2'd3;
          end
          4'h4, 4'h5:
          begin
            dec_mode = `PCC_M_DIR;
            dec_need = 2'd2;
          end
          4'hC, 4'hD:
          begin
            dec_mode = `PCC_M_IDX;
            dec_need = 2'd2;
          end
          4'hE, 4'hF:
          begin
            dec_mode = `PCC_M_IDX;
            dec_need = 2'd3;
          end
          default:
          begin
            dec_mode = `PCC_M_INH;
            dec_need = 2'd0;
          end
        endcase
      end
      default:
      begin
        dec_mode = `PCC_M_INH;
        dec_need = 2'd0;
      end
    endcase
  end

  // effective address from the captured operand bytes
  wire [15:0] idx_sel   = (page_reg == 2'd1 || page_reg == 2'd3) ?
                          index_reg_second : index_reg_first;
  reg  [15:0] ea_calc;
  always @*
  begin
    case (mode_reg)
      `PCC_M_DIR: ea_calc = {8'h00, b1_reg};
      `PCC_M_EXT: ea_calc = {b1_reg, mem_dat_i};
      `PCC_M_IDX: ea_calc = idx_sel + {8'h00, b1_reg};
      default:    ea_calc = ea_reg;
    endcase
  end

  // synchronisers and edge history
  always @(posedge clk_i)
  begin
    // mode pin syncs through reset so the first vector fetch sees it
    tb_sync_reg <= {tb_sync_reg[0], test_boot_i};
    if (rst_i)
    begin
      cm_sync_reg   <= 2'b00;
      wd_sync_reg   <= 2'b00;
      irq_sync_reg  <= 2'b00;
      nonmaskable_req_sync_reg <= 2'b00;
      cm_old_reg    <= 1'b0;
      wd_old_reg    <= 1'b0;
    end
    else
    begin
      cm_sync_reg   <= {cm_sync_reg[0], clkmon_reset_i};
      wd_sync_reg   <= {wd_sync_reg[0], watchdog_reset_cause_i};
      irq_sync_reg  <= {irq_sync_reg[0], irq_req_i};
      nonmaskable_req_sync_reg <= {nonmaskable_req_sync_reg[0], nonmaskable_req_i};
      cm_old_reg    <= cm_sync_reg[1];
      wd_old_reg    <= wd_sync_reg[1];
    end
  end

  // vector load and instruction framing
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg     <= ST_VHI;
      instr_pointer <= 16'h0000;
      vec_reg       <= `PCC_VEC_POR;
      mem_req_o     <= 1'b0;
      mem_adr_o     <= 16'h0000;
      page_reg      <= 2'd0;
      opcode_reg    <= 8'h00;
      mode_reg      <= `PCC_M_INH;
      need_reg      <= 2'd0;
      got_reg       <= 2'd0;
      b1_reg        <= 8'h00;
      opnd_reg      <= 24'h000000;
      ea_reg        <= 16'h0000;
      len_reg       <= 3'd0;
    end
    else if (cm_rise | wd_rise)
    begin
      // secondary reset causes restart the vector load
      state_reg <= ST_VHI;
      mem_req_o <= 1'b0;
      if (tb_sync_reg[1])
        vec_reg <= `PCC_VEC_TEST;
      else if (cm_rise)
        vec_reg <= `PCC_VEC_CLKMON;
      else
        vec_reg <= `PCC_VEC_WDOG;
    end
    else
    begin
      case (state_reg)
        ST_VHI:
        begin
          if (!mem_req_o)
          begin
            mem_req_o <= 1'b1;
            // power-on path picks its vector from the mode pin here
            if (tb_sync_reg[1])
              mem_adr_o <= `PCC_VEC_TEST;
            else
              mem_adr_o <= vec_reg;
          end
          else if (mem_ack_i)
          begin
            instr_pointer[15:8] <= mem_dat_i;
            mem_adr_o           <= mem_adr_o + 16'h0001;
            state_reg           <= ST_VLO;
          end
        end
        ST_VLO:
        begin
          if (mem_ack_i)
          begin
            instr_pointer[7:0] <= mem_dat_i;
            mem_req_o          <= 1'b0;
            state_reg          <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (step_cmd)
          begin
            mem_req_o <= 1'b1;
            mem_adr_o <= instr_pointer;
            page_reg  <= 2'd0;
            len_reg   <= 3'd0;
            state_reg <= ST_OP;
          end
        end
        ST_OP:
        begin
          if (mem_ack_i)
          begin
            instr_pointer <= instr_pointer + 16'h0001;
            mem_adr_o     <= instr_pointer + 16'h0001;
            len_reg       <= len_reg + 3'd1;
            if (is_pre && page_reg == 2'd0 && len_reg == 3'd0)
            begin
              // prebyte redirects decoding to another page
              page_reg <= (mem_dat_i == `PCC_PRE_P1) ? 2'd1 :
                          (mem_dat_i == `PCC_PRE_P2) ? 2'd2 : 2'd3;
            end
            else
            begin
              opcode_reg <= mem_dat_i;
              mode_reg   <= dec_mode;
              need_reg   <= dec_need;
              got_reg    <= 2'd0;
              opnd_reg   <= 24'h000000;
              if (dec_mode == `PCC_M_IMM)
                ea_reg <= instr_pointer + 16'h0001;
              if (dec_need == 2'd0)
              begin
                mem_req_o <= 1'b0;
                state_reg <= ST_IDLE;
              end
              else
                state_reg <= ST_OPND;
            end
          end
        end
        ST_OPND:
        begin
          if (mem_ack_i)
          begin
            instr_pointer <= instr_pointer + 16'h0001;
            mem_adr_o     <= instr_pointer + 16'h0001;
            len_reg       <= len_reg + 3'd1;
            got_reg       <= got_reg + 2'd1;
            opnd_reg      <= {opnd_reg[15:0], mem_dat_i};
            if (got_reg == 2'd0)
              b1_reg <= mem_dat_i;
            if (got_reg == 2'd0 && mode_reg != `PCC_M_EXT && mode_reg != `PCC_M_IMM)
              ea_reg <= (mode_reg == `PCC_M_DIR) ? {8'h00, mem_dat_i} :
                        idx_sel + {8'h00, mem_dat_i};
            if (got_reg == 2'd1 && mode_reg == `PCC_M_EXT)
              ea_reg <= ea_calc;
            if (got_reg + 2'd1 == need_reg)
            begin
              mem_req_o <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default:
          state_reg <= ST_VHI;
      endcase
    end
  end

  // flag unit, stop request and interrupt gating
  always @(posedge clk_i)
  begin
    if (rst_i | cm_rise | wd_rise)
    begin
      cond_flags_reg <= `PCC_CCR_RESET;
      stop_nop_reg   <= 1'b0;
      stop_enter_o   <= 1'b0;
      irq_take_o     <= 1'b0;
      nonmaskable_req_take_o    <= 1'b0;
    end
    else
    begin
      irq_take_o   <= irq_sync_reg[1] & ~cond_flags_reg[`PCC_F_I];
      nonmaskable_req_take_o  <= nonmaskable_req_sync_reg[1] & ~cond_flags_reg[`PCC_F_X];
      stop_enter_o <= stop_cmd & ~cond_flags_reg[`PCC_F_S];
      if (stop_cmd)
        stop_nop_reg <= cond_flags_reg[`PCC_F_S];
      if (alu_cmd)
      begin
        case (alu_op)
          `PCC_OP_ADD, `PCC_OP_ADC:
          begin
            cond_flags_reg[`PCC_F_C] <= sum9[8];
            cond_flags_reg[`PCC_F_H] <= hsum[4];
            cond_flags_reg[`PCC_F_V] <= (a8[7] == b8[7]) & (sum9[7] != a8[7]);
            cond_flags_reg[`PCC_F_Z] <= (sum9[7:0] == 8'h00);
            cond_flags_reg[`PCC_F_N] <= sum9[7];
          end
          `PCC_OP_SUB, `PCC_OP_CMP:
          begin
            cond_flags_reg[`PCC_F_C] <= dif9[8];
            cond_flags_reg[`PCC_F_V] <= (a8[7] != b8[7]) & (dif9[7] != a8[7]);
            cond_flags_reg[`PCC_F_Z] <= (dif9[7:0] == 8'h00);
            cond_flags_reg[`PCC_F_N] <= dif9[7];
          end
          `PCC_OP_AND, `PCC_OP_LOAD:
          begin
            cond_flags_reg[`PCC_F_V] <= 1'b0;
            cond_flags_reg[`PCC_F_Z] <= (alu_op == `PCC_OP_AND) ? ((a8 & b8) == 8'h00) :
                                        (b8 == 8'h00);
            cond_flags_reg[`PCC_F_N] <= (alu_op == `PCC_OP_AND) ? (a8[7] & b8[7]) :
                                        b8[7];
          end
          `PCC_OP_INC1:
            cond_flags_reg[`PCC_F_Z] <= (index_reg_first == 16'hFFFF);
          `PCC_OP_DEC1:
            cond_flags_reg[`PCC_F_Z] <= (index_reg_first == 16'h0001);
          `PCC_OP_INC2:
            cond_flags_reg[`PCC_F_Z] <= (index_reg_second == 16'hFFFF);
          `PCC_OP_DEC2:
            cond_flags_reg[`PCC_F_Z] <= (index_reg_second == 16'h0001);
          `PCC_OP_TAP, `PCC_OP_RTI:
          begin
            // nonmaskable mask may fall but never rise through TAP or RTI; INTACK with bit 0 set sets it
            cond_flags_reg <= {a8[7], a8[6] & cond_flags_reg[`PCC_F_X], a8[5:0]};
          end
          `PCC_OP_INTACK:
          begin
            cond_flags_reg[`PCC_F_I] <= 1'b1;
            if (a8[0])
              cond_flags_reg[`PCC_F_X] <= 1'b1;
          end
          `PCC_OP_ASL, `PCC_OP_ROL:
          begin
            cond_flags_reg[`PCC_F_C] <= a8[7];
            cond_flags_reg[`PCC_F_N] <= a8[6];
            cond_flags_reg[`PCC_F_Z] <= ({a8[6:0], (alu_op == `PCC_OP_ROL) &
                                          cond_flags_reg[`PCC_F_C]} == 8'h00);
            cond_flags_reg[`PCC_F_V] <= a8[6] ^ a8[7];
          end
          `PCC_OP_LSR, `PCC_OP_ROR:
          begin
            cond_flags_reg[`PCC_F_C] <= a8[0];
            cond_flags_reg[`PCC_F_N] <= (alu_op == `PCC_OP_ROR) & cond_flags_reg[`PCC_F_C];
            cond_flags_reg[`PCC_F_Z] <= ({(alu_op == `PCC_OP_ROR) &
                                          cond_flags_reg[`PCC_F_C], a8[7:1]} == 8'h00);
            cond_flags_reg[`PCC_F_V] <= ((alu_op == `PCC_OP_ROR) &
                                         cond_flags_reg[`PCC_F_C]) ^ a8[0];
          end
          default:
            cond_flags_reg <= cond_flags_reg;
        endcase
      end
    end
  end

  // results and index registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alu_a_reg        <= 16'h0000;
      alu_b_reg        <= 16'h0000;
      result_reg       <= 16'h0000;
      index_reg_first  <= 16'h0000;
      index_reg_second <= 16'h0000;
    end
    else if (wb_wr)
    begin
      case (adr_i)
        `PCC_R_ALUA: alu_a_reg        <= dat_i[15:0];
        `PCC_R_ALUB: alu_b_reg        <= dat_i[15:0];
        `PCC_R_IDX1: index_reg_first  <= dat_i[15:0];
        `PCC_R_IDX2: index_reg_second <= dat_i[15:0];
        `PCC_R_ALUCMD:
        begin
          case (alu_op)
            `PCC_OP_ADD, `PCC_OP_ADC: result_reg <= {8'h00, sum9[7:0]};
            `PCC_OP_SUB:              result_reg <= {8'h00, dif9[7:0]};
            `PCC_OP_AND:              result_reg <= {8'h00, a8 & b8};
            `PCC_OP_LOAD:             result_reg <= {8'h00, b8};
            `PCC_OP_ASL:              result_reg <= {8'h00, a8[6:0], 1'b0};
            `PCC_OP_ROL:              result_reg <= {8'h00, a8[6:0], cond_flags_reg[`PCC_F_C]};
            `PCC_OP_LSR:              result_reg <= {8'h00, 1'b0, a8[7:1]};
            `PCC_OP_ROR:              result_reg <= {8'h00, cond_flags_reg[`PCC_F_C], a8[7:1]};
            `PCC_OP_INC1: index_reg_first  <= index_reg_first + 16'h0001;
            `PCC_OP_DEC1: index_reg_first  <= index_reg_first - 16'h0001;
            `PCC_OP_INC2: index_reg_second <= index_reg_second + 16'h0001;
            `PCC_OP_DEC2: index_reg_second <= index_reg_second - 16'h0001;
            `PCC_OP_ABX1: index_reg_first  <= index_reg_first + {8'h00, b8};
            `PCC_OP_ABX2: index_reg_second <= index_reg_second + {8'h00, b8};
            `PCC_OP_NOFLAG: result_reg <= alu_a_reg;
            default:      result_reg <= result_reg;
          endcase
        end
        default: result_reg <= result_reg;
      endcase
    end
  end

  // wishbone answer one cycle after the request
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= wb_req;
      if (wb_req)
      begin
        case (adr_i)
          `PCC_R_STAT:   dat_o <= {16'h0000, 1'b0, len_reg, mode_reg, page_reg,
                                   stop_nop_reg, nonmaskable_req_sync_reg[1], irq_sync_reg[1],
                                   1'b0, state_reg};
          `PCC_R_IP:     dat_o <= {16'h0000, instr_pointer};
          `PCC_R_EA:     dat_o <= {16'h0000, ea_reg};
          `PCC_R_INSTR:  dat_o <= {opnd_reg, opcode_reg};
          `PCC_R_CCR:    dat_o <= {24'h000000, cond_flags_reg};
          `PCC_R_ALUA:   dat_o <= {16'h0000, alu_a_reg};
          `PCC_R_ALUB:   dat_o <= {16'h0000, alu_b_reg};
          `PCC_R_RESULT: dat_o <= {16'h0000, result_reg};
          `PCC_R_IDX1:   dat_o <= {16'h0000, index_reg_first};
          `PCC_R_IDX2:   dat_o <= {16'h0000, index_reg_second};
          default:       dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- pkg/pcc_defs.vh ----
// constants for the program counter, flag and addressing core
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH
// reset vectors
`define PCC_VEC_POR      16'hFFFE
`define PCC_VEC_CLKMON   16'hFFFC
`define PCC_VEC_WDOG     16'hFFFA
`define PCC_VEC_TEST     16'hBFFE
// flag bit positions
`define PCC_F_C          0
`define PCC_F_V          1
`define PCC_F_Z          2
`define PCC_F_N          3
`define PCC_F_I          4
`define PCC_F_H          5
`define PCC_F_X          6
`define PCC_F_S          7
`define PCC_CCR_RESET    8'hD0
// prebytes for pages one to three
`define PCC_PRE_P1       8'h18
`define PCC_PRE_P2       8'h1A
`define PCC_PRE_P3       8'hCD
// register byte offsets
`define PCC_R_CTRL       8'h00
`define PCC_R_STAT       8'h04
`define PCC_R_IP         8'h08
`define PCC_R_EA         8'h0C
`define PCC_R_INSTR      8'h10
`define PCC_R_CCR        8'h14
`define PCC_R_ALUCMD     8'h18
`define PCC_R_ALUA       8'h1C
`define PCC_R_ALUB       8'h20
`define PCC_R_RESULT     8'h24
`define PCC_R_IDX1       8'h28
`define PCC_R_IDX2       8'h2C
// control bits
`define PCC_CTRL_STEP    0
`define PCC_CTRL_STOP    1
// flag unit operations
`define PCC_OP_ADD       5'h00
`define PCC_OP_ADC       5'h01
`define PCC_OP_SUB       5'h02
`define PCC_OP_CMP       5'h03
`define PCC_OP_AND       5'h04
`define PCC_OP_LOAD      5'h05
`define PCC_OP_INC1      5'h06
`define PCC_OP_DEC1      5'h07
`define PCC_OP_INC2      5'h08
`define PCC_OP_DEC2      5'h09
`define PCC_OP_ABX1      5'h0A
`define PCC_OP_ABX2      5'h0B
`define PCC_OP_NOFLAG    5'h0C
`define PCC_OP_TAP       5'h0D
`define PCC_OP_RTI       5'h0E
`define PCC_OP_INTACK    5'h0F
`define PCC_OP_ASL       5'h10
`define PCC_OP_ROL       5'h11
`define PCC_OP_LSR       5'h12
`define PCC_OP_ROR       5'h13
// addressing modes
`define PCC_M_INH        3'h0
`define PCC_M_IMM        3'h1
`define PCC_M_DIR        3'h2
`define PCC_M_EXT        3'h3
`define PCC_M_IDX        3'h4
`endif
